// >>> logic/pifb_top.sv
`timescale 1ns/1ps
module pifb_top
   import pifb_pkg::*;
#(
   parameter int HOLD_CYCLES = HOLDOFF_CYCLES
)
(
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   input  wire logic [DATA_W-1:0] ov_event,
   input  wire logic [DATA_W-1:0] uv_event,
   input  wire logic [DATA_W-1:0] misc_event,
   input  wire logic [DATA_W-1:0] diag_event,
   input  wire logic [DATA_W-1:0] ov_selfcheck_fail,
   input  wire logic [DATA_W-1:0] uv_selfcheck_fail,
   input  wire logic [DATA_W-1:0] misc_selfcheck_fail,
   input  wire logic [DATA_W-1:0] diag_selfcheck_fail,
   input  wire logic              system_reset_out_n,
   input  wire logic [DATA_W-1:0] ov_mask,
   input  wire logic [DATA_W-1:0] uv_mask,
   input  wire logic [DATA_W-1:0] misc_mask,
   input  wire logic [DATA_W-1:0] diag_mask,
   output logic                   irq_out_n
);

   // ----------------------------------------
   // decode
   // ----------------------------------------
   function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
      wr_hit = reg_wr && (reg_addr == a);
   endfunction

   function automatic logic [DATA_W-1:0] clr_of(input logic [ADDR_W-1:0] a,
                                                input logic [DATA_W-1:0] m);
      clr_of = wr_hit(a) ? (reg_wdata & m) : ZERO_BYTE;
   endfunction

   logic [DATA_W-1:0] overvoltage_requests;
   logic [DATA_W-1:0] undervoltage_requests;
   logic [DATA_W-1:0] misc_requests;
   logic [DATA_W-1:0] diagnosis_requests;
   logic [DATA_W-1:0] overvoltage_clear;
   logic [DATA_W-1:0] undervoltage_clear;
   logic [DATA_W-1:0] misc_clear;
   logic [DATA_W-1:0] diagnosis_clear;
   logic [DATA_W-1:0] ov_set;
   logic [DATA_W-1:0] uv_set;
   logic [DATA_W-1:0] misc_set;
   logic [DATA_W-1:0] diag_set;
   logic [DATA_W-1:0] irq_group_summary;
   logic [3:0]        group_pending;
   logic              test_bit;
   logic              test_bit_clear;
   logic              selfcheck_fail_present;
   logic              reset_cause_present;
   logic              rst_out_seen_n;
   logic              any_selfcheck;
   logic              any_request;
   logic              any_clear;
   logic              unmasked_any;
   logic              hold_busy;

   assign overvoltage_clear   = clr_of(ADDR_OV_CLEAR, OV_VALID);
   assign undervoltage_clear  = clr_of(ADDR_UV_CLEAR, UV_VALID);
   assign misc_clear          = clr_of(ADDR_MISC_CLEAR, MISC_VALID);
   assign diagnosis_clear     = clr_of(ADDR_DIAG_CLEAR, DIAG_CLR_MASK);
   assign test_bit_clear      = diagnosis_clear[DIAG_TEST_BIT];
   assign any_clear           = |{overvoltage_clear, undervoltage_clear,
                                  misc_clear, diagnosis_clear};

   // ----------------------------------------
   // request sources
   // ----------------------------------------
   // self-check failures land in the block's own bit
   assign ov_set   = (ov_event | ov_selfcheck_fail) & OV_VALID;
   assign uv_set   = (uv_event | uv_selfcheck_fail) & UV_VALID;
   assign misc_set = (misc_event | misc_selfcheck_fail) & MISC_VALID;

   // test request rises only on a write of one to the test bit
   always_comb
   begin
      diag_set = (diag_event | diag_selfcheck_fail) & DIAG_HW_VALID;
      diag_set[DIAG_TEST_BIT] = wr_hit(ADDR_DIAG_REQ)
                                && reg_wdata[DIAG_TEST_BIT];
   end

   // unused bit positions must not raise the self-check flag on their own
   assign any_selfcheck = |{ov_selfcheck_fail & OV_VALID,
                            uv_selfcheck_fail & UV_VALID,
                            misc_selfcheck_fail & MISC_VALID,
                            diag_selfcheck_fail & DIAG_HW_VALID};

   // ----------------------------------------
   // request registers
   // ----------------------------------------
   // plain rst only; the system reset output never reaches these
   pifb_flag_reg #(
      .WIDTH    (DATA_W),
      .VALID    (OV_VALID)
   ) u_ov (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .ce       (ce),
      .set_bits (ov_set),
      .clr_bits (overvoltage_clear),
      .q        (overvoltage_requests)
   );

   // reg2 low flag keeps its value across the reset it caused
   pifb_flag_reg #(
      .WIDTH    (DATA_W),
      .VALID    (UV_VALID)
   ) u_uv (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .ce       (ce),
      .set_bits (uv_set),
      .clr_bits (undervoltage_clear),
      .q        (undervoltage_requests)
   );

   pifb_flag_reg #(
      .WIDTH    (DATA_W),
      .VALID    (MISC_VALID)
   ) u_misc (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .ce       (ce),
      .set_bits (misc_set),
      .clr_bits (misc_clear),
      .q        (misc_requests)
   );

   pifb_flag_reg #(
      .WIDTH    (DATA_W),
      .VALID    (DIAG_VALID)
   ) u_diag (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .ce       (ce),
      .set_bits (diag_set),
      .clr_bits (diagnosis_clear),
      .q        (diagnosis_requests)
   );

   // ----------------------------------------
   // software test bit
   // ----------------------------------------
   // readable copy; the request itself needs the clear write
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         test_bit <= 1'b0;
      else if (ce && wr_hit(ADDR_DIAG_REQ))
         test_bit <= reg_wdata[DIAG_TEST_BIT];
   end

   // ----------------------------------------
   // summary
   // ----------------------------------------
   assign group_pending = {|diagnosis_requests, |misc_requests,
                           |undervoltage_requests,
                           |overvoltage_requests};
   assign any_request   = |group_pending;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         selfcheck_fail_present <= 1'b0;
      else if (ce)
         selfcheck_fail_present <= any_selfcheck
                                   || (selfcheck_fail_present
                                       && any_request);
   end

   // a falling reset output marks that a reset factor fired
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         rst_out_seen_n <= 1'b1;
      else if (ce)
         rst_out_seen_n <= system_reset_out_n;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         reset_cause_present <= 1'b0;
      else if (ce)
         reset_cause_present <= (rst_out_seen_n && !system_reset_out_n)
                                || (reset_cause_present
                                    && any_request);
   end

   always_comb
   begin
      irq_group_summary = ZERO_BYTE;
      irq_group_summary[SUM_GROUP_LSB +: 4]  = group_pending;
      irq_group_summary[SUM_SELFCHECK_BIT]   = selfcheck_fail_present;
      irq_group_summary[SUM_RESET_CAUSE_BIT] = reset_cause_present;
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   // clear registers and holes read back as zero
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         reg_rdata <= ZERO_BYTE;
      end
      else if (ce && reg_rd)
      begin
         unique case (reg_addr)
            ADDR_SUMMARY:  reg_rdata <= irq_group_summary;
            ADDR_OV_REQ:   reg_rdata <= overvoltage_requests;
            ADDR_UV_REQ:   reg_rdata <= undervoltage_requests;
            ADDR_MISC_REQ: reg_rdata <= misc_requests;
            ADDR_DIAG_REQ: reg_rdata <= {test_bit,
                                         diagnosis_requests[DIAG_TEST_BIT-1:0]};
            default:       reg_rdata <= ZERO_BYTE;
         endcase
      end
   end

   // ----------------------------------------
   // interrupt pin
   // ----------------------------------------
   pifb_holdoff #(
      .CYCLES   (HOLD_CYCLES)
   ) u_hold (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .ce       (ce),
      .start    (any_clear),
      .busy     (hold_busy)
   );

   assign unmasked_any = |{overvoltage_requests & ~ov_mask,
                           undervoltage_requests & ~uv_mask,
                           misc_requests & ~misc_mask,
                           diagnosis_requests & ~diag_mask};

   // the clear cycle itself is gated too, so no glitch low
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         irq_out_n <= 1'b1;
      else if (ce)
         irq_out_n <= !(unmasked_any && !hold_busy && !any_clear);
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   irq_assert_a: assert property (
      (ce && unmasked_any && !hold_busy && !any_clear) |=> !irq_out_n)
      else $error("irq pin not driven low");

   irq_release_a: assert property (
      (ce && !unmasked_any) |=> irq_out_n)
      else $error("irq pin low with nothing unmasked");

   clear_hold_a: assert property (
      (ce && any_clear) |=> irq_out_n [*2])
      else $error("irq pin low right after a clear");

   summary_read_a: assert property (
      (ce && reg_rd && reg_addr == ADDR_SUMMARY)
      |=> reg_rdata[3:0] == $past(group_pending))
      else $error("summary group bits wrong");

   selfcheck_flag_a: assert property (
      (ce && |(ov_selfcheck_fail & OV_VALID))
      |=> selfcheck_fail_present && group_pending[0])
      else $error("self-check not reported");

   reset_cause_a: assert property (
      (ce && reset_cause_present && any_request)
      |=> reset_cause_present)
      else $error("reset cause dropped early");

   keep_on_reset_a: assert property (
      (ce && !system_reset_out_n && !any_clear)
      |=> (undervoltage_requests & $past(undervoltage_requests))
          == $past(undervoltage_requests))
      else $error("request lost at reset output");

   ov_unused_a: assert property (
      !overvoltage_requests[7] && !misc_requests[7])
      else $error("unused request bit set");

   test_raise_a: assert property (
      (ce && wr_hit(ADDR_DIAG_REQ) && reg_wdata[DIAG_TEST_BIT])
      |=> test_bit && diagnosis_requests[DIAG_TEST_BIT])
      else $error("test interrupt not raised");

   ov_clear_a: assert property (
      (ce && wr_hit(ADDR_OV_CLEAR) && !(|ov_event)
       && !(|ov_selfcheck_fail))
      |=> (overvoltage_requests & $past(reg_wdata)) == ZERO_BYTE)
      else $error("over-voltage clear failed");

   diag_noclear_a: assert property (
      (ce && wr_hit(ADDR_DIAG_CLEAR)
       && diagnosis_requests[DIAG_NOCLEAR_BIT])
      |=> diagnosis_requests[DIAG_NOCLEAR_BIT])
      else $error("diagnosis bit 6 was cleared");

   test_clear_a: assert property (
      (ce && test_bit_clear && !diag_set[DIAG_TEST_BIT])
      |=> !diagnosis_requests[DIAG_TEST_BIT])
      else $error("test request not cleared");

   mask_block_a: assert property (
      (ce && (overvoltage_requests & ov_mask) != ZERO_BYTE
       && (overvoltage_requests & ~ov_mask) == ZERO_BYTE
       && undervoltage_requests == ZERO_BYTE
       && misc_requests == ZERO_BYTE
       && diagnosis_requests == ZERO_BYTE)
      |=> irq_out_n)
      else $error("masked factor drove irq pin");

endmodule

// >>> common/pifb_pkg.sv
package pifb_pkg;

   // ----------------------------------------
   // register port
   // ----------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;

   localparam logic [ADDR_W-1:0] ADDR_SUMMARY    = 6'h03;
   localparam logic [ADDR_W-1:0] ADDR_OV_REQ     = 6'h04;
   localparam logic [ADDR_W-1:0] ADDR_UV_REQ     = 6'h05;
   localparam logic [ADDR_W-1:0] ADDR_MISC_REQ   = 6'h06;
   localparam logic [ADDR_W-1:0] ADDR_DIAG_REQ   = 6'h07;
   localparam logic [ADDR_W-1:0] ADDR_OV_CLEAR   = 6'h08;
   localparam logic [ADDR_W-1:0] ADDR_UV_CLEAR   = 6'h09;
   localparam logic [ADDR_W-1:0] ADDR_MISC_CLEAR = 6'h0a;
   localparam logic [ADDR_W-1:0] ADDR_DIAG_CLEAR = 6'h0b;

   // ----------------------------------------
   // field layout
   // ----------------------------------------
   localparam int SUM_GROUP_LSB      = 0;
   localparam int SUM_SELFCHECK_BIT  = 4;
   localparam int SUM_RESET_CAUSE_BIT = 5;
   localparam int UV_REG2_LOW_BIT    = 3;
   localparam int MISC_CW_TRIG_BIT   = 4;
   localparam int DIAG_TEST_BIT      = 7;
   localparam int DIAG_NOCLEAR_BIT   = 6;

   // bits that exist in each request register
   localparam logic [DATA_W-1:0] OV_VALID      = 8'h7f;
   localparam logic [DATA_W-1:0] UV_VALID      = 8'hff;
   localparam logic [DATA_W-1:0] MISC_VALID    = 8'h7f;
   localparam logic [DATA_W-1:0] DIAG_HW_VALID = 8'h7f;
   localparam logic [DATA_W-1:0] DIAG_VALID    = 8'hff;
   // clear positions that really clear in the diagnosis clear register
   localparam logic [DATA_W-1:0] DIAG_CLR_MASK = 8'hbf;

   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [DATA_W-1:0] RESET_VAL = 8'h00;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int HOLDOFF_US      = 500;
   localparam int CLK_MHZ         = 125;
   localparam int HOLDOFF_CYCLES  = HOLDOFF_US * CLK_MHZ;
   localparam int HOLDOFF_MIN     = 2;

   typedef enum logic {
      PIFB_HOLD_IDLE = 1'b0,
      PIFB_HOLD_BUSY = 1'b1
   } pifb_hold_t;

endpackage

// >>> logic/pifb_flag_reg.sv
`timescale 1ns/1ps
module pifb_flag_reg
   import pifb_pkg::*;
#(
   parameter int                 WIDTH = DATA_W,
   parameter logic [WIDTH-1:0]   VALID = '1
)
(
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] set_bits,
   input  wire logic [WIDTH-1:0] clr_bits,
   output logic      [WIDTH-1:0] q
);

   // ----------------------------------------
   // sticky flags
   // ----------------------------------------
   // a set in the clearing cycle survives the clear
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         q <= '0;
      end
      else if (ce)
      begin
         q <= ((q & ~clr_bits) | set_bits) & VALID;
      end
   end

endmodule

// >>> logic/pifb_holdoff.sv
`timescale 1ns/1ps
module pifb_holdoff
   import pifb_pkg::*;
#(
   parameter int CYCLES = HOLDOFF_CYCLES
)
(
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic start,
   output logic      busy
);

   localparam int CW = $clog2(CYCLES + 1);

   pifb_hold_t    state;
   logic [CW-1:0] count;

   if (CYCLES < HOLDOFF_MIN)
   begin : g_chk
      $error("hold-off too short");
   end

   // ----------------------------------------
   // hold-off timer
   // ----------------------------------------
   // a new clear restarts the full wait
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state <= PIFB_HOLD_IDLE;
         count <= '0;
      end
      else if (ce)
      begin
         if (start)
         begin
            state <= PIFB_HOLD_BUSY;
            count <= CW'(CYCLES - 1);
         end
         else
         begin
            unique case (state)
               PIFB_HOLD_IDLE:
                  count <= '0;
               PIFB_HOLD_BUSY:
               begin
                  if (count == '0)
                     state <= PIFB_HOLD_IDLE;
                  else
                     count <= count - 1'b1;
               end
            endcase
         end
      end
   end

   assign busy = (state == PIFB_HOLD_BUSY);

endmodule

// >>> verif/pifb_host_model.sv
`timescale 1ns/1ps
module pifb_host_model
   import pifb_pkg::*;
(
   input  wire logic              clk_sys,
   output logic      [ADDR_W-1:0] reg_addr,
   output logic      [DATA_W-1:0] reg_wdata,
   output logic                   reg_wr,
   output logic                   reg_rd,
   input  wire logic [DATA_W-1:0] reg_rdata
);
   // ----------------------------------------
   // register port master
   // ----------------------------------------
   initial
   begin
      reg_addr = 6'h3f;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // released lines show the inverse, never a stale value
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask

   // test bit first to zero, then its clear position; mid = summary between
   task automatic ack_test_bit(output logic [DATA_W-1:0] mid);
      wr(ADDR_DIAG_REQ, 8'h00);
      rd(ADDR_SUMMARY, mid);
      wr(ADDR_DIAG_CLEAR, 8'h80);
   endtask
endmodule

// >>> verif/pmic_interrupt_flag_bank_tb.sv
`timescale 1ns/1ps
module pmic_interrupt_flag_bank_tb
   import pifb_pkg::*;
;
   localparam int HOLD = 16;
   logic              clk_sys;
   logic              rst;
   logic              ce;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   logic [DATA_W-1:0] ev [4];
   logic [DATA_W-1:0] sc [4];
   logic [DATA_W-1:0] mk [4];
   logic              system_reset_out_n;
   logic              irq_out_n;
   logic [DATA_W-1:0] rv;
   int                n_fail;
   int                samples_checked;
   // {group, event bits, request expected, summary expected}
   logic [31:0]       rows [8] = '{32'h00_40_40_01, 32'h00_80_00_00,
                                   32'h01_80_80_02, 32'h01_08_08_02,
                                   32'h02_01_01_04, 32'h02_80_00_00,
                                   32'h03_01_01_08, 32'h03_80_00_00};

   // ----------------------------------------
   // design and host
   // ----------------------------------------
   pifb_top #(.HOLD_CYCLES(HOLD)) DUT (
      .clk_sys(clk_sys), .rst(rst), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ov_event(ev[0]), .uv_event(ev[1]),
      .misc_event(ev[2]), .diag_event(ev[3]),
      .ov_selfcheck_fail(sc[0]), .uv_selfcheck_fail(sc[1]),
      .misc_selfcheck_fail(sc[2]), .diag_selfcheck_fail(sc[3]),
      .system_reset_out_n(system_reset_out_n),
      .ov_mask(mk[0]), .uv_mask(mk[1]),
      .misc_mask(mk[2]), .diag_mask(mk[3]),
      .irq_out_n(irq_out_n));

   pifb_host_model host (
      .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] seen,
                      input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic rdc(input logic [5:0] a, input logic [7:0] e,
                      input string nm);
      host.rd(a, rv);
      chk(nm, rv, e);
   endtask

   task automatic irq_is(input logic e);
      chk("irq_out_n", {7'h00, irq_out_n}, {7'h00, e});
   endtask

   // one-cycle detector or self-check pulse
   task automatic pulse(input logic [1:0] g, input logic [7:0] b,
                        input logic selfcheck);
      @(negedge clk_sys);
      if (selfcheck)
         sc[g] = b;
      else
         ev[g] = b;
      @(negedge clk_sys);
      sc[g] = 8'h00;
      ev[g] = 8'h00;
   endtask

   // ----------------------------------------
   // watchdog
   // ----------------------------------------
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      report_and_stop();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      n_fail = 0;
      samples_checked = 0;
      rst = 1'b1;
      ce = 1'b1;
      system_reset_out_n = 1'b1;
      for (int g = 0; g < 4; g++)
      begin
         ev[g] = 8'h00;
         sc[g] = 8'h00;
         mk[g] = 8'h00;
      end
      cyc(4);
      rst = 1'b0;
      for (int a = 3; a < 12; a++)
         rdc(6'(a), 8'h00, "reset value");
      rdc(6'h3f, 8'h00, "unmapped");
      irq_is(1'b1);
      $display("test reset done");

      for (int i = 0; i < 8; i++)
      begin
         pulse(rows[i][25:24], rows[i][23:16], 1'b0);
         cyc(2);
         irq_is(rows[i][15:8] == 8'h00);
         rdc(ADDR_OV_REQ + 6'(rows[i][25:24]), rows[i][15:8], "req");
         rdc(ADDR_SUMMARY, rows[i][7:0], "summary");
         host.wr(ADDR_OV_CLEAR + 6'(rows[i][25:24]), rows[i][23:16]);
         cyc(2);
         rdc(ADDR_OV_REQ + 6'(rows[i][25:24]), 8'h00, "req cleared");
         rdc(ADDR_SUMMARY, 8'h00, "summary cleared");
         cyc(HOLD + 4);
      end
      $display("test table done");

      pulse(2'd1, 8'h08, 1'b1);
      cyc(2);
      rdc(ADDR_UV_REQ, 8'h08, "selfcheck req");
      rdc(ADDR_SUMMARY, 8'h12, "selfcheck sum");
      host.wr(ADDR_UV_CLEAR, 8'h08);
      cyc(2);
      rdc(ADDR_SUMMARY, 8'h00, "selfcheck gone");
      cyc(HOLD + 4);
      $display("test selfcheck done");

      @(negedge clk_sys);
      ev[1] = 8'h08;
      system_reset_out_n = 1'b0;
      @(negedge clk_sys);
      ev[1] = 8'h00;
      cyc(4);
      system_reset_out_n = 1'b1;
      cyc(2);
      rdc(ADDR_UV_REQ, 8'h08, "reg2 low kept");
      pulse(2'd0, 8'h01, 1'b0);
      host.wr(ADDR_UV_CLEAR, 8'h08);
      cyc(2);
      rdc(ADDR_SUMMARY, 8'h21, "cause kept");
      host.wr(ADDR_OV_CLEAR, 8'h01);
      cyc(2);
      rdc(ADDR_SUMMARY, 8'h00, "cause gone");
      cyc(HOLD + 4);
      $display("test reset cause done");

      host.wr(ADDR_DIAG_REQ, 8'h7f);
      rdc(ADDR_DIAG_REQ, 8'h00, "diag read only");
      host.wr(ADDR_DIAG_REQ, 8'h80);
      cyc(2);
      irq_is(1'b0);
      rdc(ADDR_DIAG_REQ, 8'h80, "test bit");
      host.ack_test_bit(rv);
      chk("request after zero", rv, 8'h08);
      cyc(2);
      rdc(ADDR_SUMMARY, 8'h00, "test acked");
      cyc(HOLD + 4);
      $display("test test bit done");

      mk[0] = 8'h01;
      pulse(2'd0, 8'h01, 1'b0);
      cyc(3);
      irq_is(1'b1);
      rdc(ADDR_OV_REQ, 8'h01, "masked stored");
      mk[0] = 8'h00;
      cyc(3);
      irq_is(1'b0);
      pulse(2'd0, 8'h02, 1'b0);
      host.wr(ADDR_OV_CLEAR, 8'h00);
      irq_is(1'b0);
      host.wr(ADDR_OV_CLEAR, 8'h01);
      irq_is(1'b1);
      cyc(HOLD - 2);
      irq_is(1'b1);
      cyc(6);
      irq_is(1'b0);
      rdc(ADDR_OV_REQ, 8'h02, "other kept");
      host.wr(ADDR_OV_CLEAR, 8'h02);
      cyc(HOLD + 4);
      irq_is(1'b1);
      $display("test mask and hold-off done");

      // clock enable low: events, reads and the pin all freeze
      ce = 1'b0;
      pulse(2'd0, 8'h04, 1'b0);
      host.rd(ADDR_SUMMARY, rv);
      chk("frozen rdata", rv, 8'h02);
      ce = 1'b1;
      rdc(ADDR_OV_REQ, 8'h00, "frozen flags");
      irq_is(1'b1);
      $display("test clock enable done");

      pulse(2'd3, 8'h40, 1'b0);
      host.wr(ADDR_DIAG_CLEAR, 8'h40);
      cyc(2);
      rdc(ADDR_DIAG_REQ, 8'h40, "no clear bit");
      @(negedge clk_sys);
      rst = 1'b1;
      cyc(4);
      rst = 1'b0;
      rdc(ADDR_DIAG_REQ, 8'h00, "second reset");
      irq_is(1'b1);
      $display("test second reset done");
      report_and_stop();
   end
endmodule
